// ---- design/vcsfsm_pkg.sv ----
/*
 * Shared types and constants of the cable-supply swap state machine.
 * Assumes a 125 MHz policy engine clock; the supply-on timeout figure is a
 * plain default to be replaced by the system value.
 */
package vcsfsm_pkg;

  // Clock rate and supply-on timeout
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SUPPLY_ON_TIME_US = 100000;
  localparam int unsigned SUPPLY_ON_CYCLES = (SUPPLY_ON_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned TIMER_WIDTH = 32;

  // Values after reset
  localparam logic RST_SUPPLY_ON_REQ = 1'b0;
  localparam logic RST_SUPPLY_OFF_REQ = 1'b0;

  // States, Gray coded along the responder path
  typedef enum logic [3:0] {
    ready_state = 4'h0,
    eval_state = 4'h1,
    responder_accept_state = 4'h3,
    responder_wait_partner_state = 4'h2,
    responder_supply_off_state = 4'h6,
    responder_supply_on_state = 4'h7,
    responder_send_ready_state = 4'h5,
    responder_refuse_state = 4'h4,
    initiator_supply_on_state = 4'hc,
    initiator_send_ready_state = 4'hd,
    hard_reset_state = 4'hf
  } vcsfsm_state_type;

  // Messages handed to the protocol layer
  typedef enum logic [1:0] {
    msg_ps_rdy = 2'h0,
    msg_accept = 2'h1,
    msg_reject = 2'h2,
    msg_wait = 2'h3
  } vcsfsm_msg_type;

  // Transmit request towards the protocol layer
  typedef struct packed {
    logic req;
    vcsfsm_msg_type msg;
  } vcsfsm_tx_type;

  // Events and status from the protocol layer
  typedef struct packed {
    logic swap_rcvd;
    logic ps_rdy_rcvd;
    logic tx_done;
  } vcsfsm_rx_type;

  // Answers and status from the policy manager
  typedef struct packed {
    logic supply_is_on;
    logic swap_ok;
    logic swap_reject;
    logic swap_wait;
    logic initiator_go;
    logic hard_reset_done;
  } vcsfsm_dpm_in_type;

  // Requests towards the policy manager
  typedef struct packed {
    logic supply_on_req;
    logic supply_off_req;
    logic eval_req;
  } vcsfsm_dpm_out_type;

  // Whole state of the machine
  typedef struct packed {
    vcsfsm_state_type fsm;
    logic [TIMER_WIDTH-1:0] timer;
    vcsfsm_tx_type tx;
    vcsfsm_dpm_out_type dpm;
    logic hard_reset_src;
    logic hard_reset_snk;
  } vcsfsm_regs_type;

endpackage : vcsfsm_pkg

// ---- design/vcsfsm_top.sv ----
/*
 * Cable-supply swap policy state machine: initiator tail and full
 * responder path. Assumes the protocol layer answers each transmit
 * request with a one-cycle tx_done and the policy manager reports the
 * supply state as a level and its swap verdict as one-cycle pulses.
 */
// What this block does
// RQ1 - In initiator supply-on it asks for the supply and moves to send-ready once it is on.
// RQ2 - In initiator send-ready it sends PS_RDY and then returns to the ready state of its role.
// RQ3 - While evaluating a swap request it goes to accept when the manager says the swap is fine.
// RQ4 - While evaluating a swap request it goes to refuse when the manager says it cannot be done.
// RQ5 - In responder accept it sends an Accept message.
// RQ6 - After Accept is sent with its own supply on it waits for the partner's supply.
// RQ7 - After Accept is sent with its own supply off it goes to responder supply-on.
// RQ8 - In responder refuse it sends Reject when impossible now, or Wait when more thought is needed.
// RQ9 - After Reject or Wait has gone out it returns to the ready state.
// RQ10 - In the wait state it runs the supply-on timer and goes to supply-off on a received PS_RDY.
// RQ11 - If the supply-on timer expires while waiting it enters hard reset for its power role.
// RQ12 - In responder supply-off it asks for the supply off and returns to ready once it is off.
// RQ13 - In responder supply-on it asks for the supply and moves to send-ready once it is on.
// RQ14 - In responder send-ready it sends a PS_RDY message.
// RQ15 - After the responder's PS_RDY has gone out it returns to the ready state of its role.
// RQ16 - A swap request received in ready starts an evaluation by the manager; peers ask only from ready.
`timescale 1ns/100ps

module vcsfsm_top #(
  parameter int unsigned SUPPLY_ON_CYCLES = vcsfsm_pkg::SUPPLY_ON_CYCLES
) (
  input wire logic ref_clk, // Policy engine clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic role_is_source, // Present power role: 1 source, 0 sink
  input wire vcsfsm_pkg::vcsfsm_rx_type rx, // Protocol layer events
  input wire vcsfsm_pkg::vcsfsm_dpm_in_type dpm_in, // Policy manager answers
  output vcsfsm_pkg::vcsfsm_tx_type tx, // Message transmit request
  output vcsfsm_pkg::vcsfsm_dpm_out_type dpm_out, // Policy manager requests
  output logic source_ready, // In source ready state
  output logic sink_ready, // In sink ready state
  output logic hard_reset_src, // In source hard reset state
  output logic hard_reset_snk // In sink hard reset state
);

  vcsfsm_pkg::vcsfsm_regs_type state_reg;
  vcsfsm_pkg::vcsfsm_regs_type state_next;

  localparam logic [vcsfsm_pkg::TIMER_WIDTH-1:0] TIMER_LAST =
    vcsfsm_pkg::TIMER_WIDTH'(SUPPLY_ON_CYCLES - 1);

  // Next state, timer and registered outputs
  always_comb begin
    state_next = state_reg;
    unique case (state_reg.fsm)
      vcsfsm_pkg::ready_state: begin
        // RQ16 swap request evaluated
        if (rx.swap_rcvd) begin
          state_next.fsm = vcsfsm_pkg::eval_state;
        end else if (dpm_in.initiator_go) begin
          state_next.fsm = vcsfsm_pkg::initiator_supply_on_state;
        end
      end
      vcsfsm_pkg::eval_state: begin
        // RQ3 accept on approval
        if (dpm_in.swap_ok) begin
          state_next.fsm = vcsfsm_pkg::responder_accept_state;
          state_next.tx.msg = vcsfsm_pkg::msg_accept;
        // RQ4 refuse when not possible
        end else if (dpm_in.swap_reject || dpm_in.swap_wait) begin
          state_next.fsm = vcsfsm_pkg::responder_refuse_state;
          // RQ8 reject wins over wait
          state_next.tx.msg = dpm_in.swap_reject ? vcsfsm_pkg::msg_reject
                                                 : vcsfsm_pkg::msg_wait;
        end
      end
      vcsfsm_pkg::responder_accept_state: begin
        if (rx.tx_done) begin
          // RQ6 own supply on, wait
          if (dpm_in.supply_is_on) begin
            state_next.fsm = vcsfsm_pkg::responder_wait_partner_state;
            state_next.timer = '0;
          // RQ7 own supply off, turn on
          end else begin
            state_next.fsm = vcsfsm_pkg::responder_supply_on_state;
          end
        end
      end
      vcsfsm_pkg::responder_refuse_state: begin
        // RQ9 back to ready
        if (rx.tx_done) begin
          state_next.fsm = vcsfsm_pkg::ready_state;
        end
      end
      vcsfsm_pkg::responder_wait_partner_state: begin
        // RQ10 partner supply ready
        if (rx.ps_rdy_rcvd) begin
          state_next.fsm = vcsfsm_pkg::responder_supply_off_state;
        // RQ11 timer expiry hard reset
        end else if (state_reg.timer >= TIMER_LAST) begin
          state_next.fsm = vcsfsm_pkg::hard_reset_state;
        end else begin
          state_next.timer = state_reg.timer + 1'b1;
        end
      end
      vcsfsm_pkg::responder_supply_off_state: begin
        // RQ12 supply off, ready
        if (!dpm_in.supply_is_on) begin
          state_next.fsm = vcsfsm_pkg::ready_state;
        end
      end
      vcsfsm_pkg::responder_supply_on_state: begin
        // RQ13 supply on, send ready
        if (dpm_in.supply_is_on) begin
          state_next.fsm = vcsfsm_pkg::responder_send_ready_state;
          state_next.tx.msg = vcsfsm_pkg::msg_ps_rdy;
        end
      end
      vcsfsm_pkg::responder_send_ready_state: begin
        // RQ15 back to ready
        if (rx.tx_done) begin
          state_next.fsm = vcsfsm_pkg::ready_state;
        end
      end
      vcsfsm_pkg::initiator_supply_on_state: begin
        // RQ1 supply on, send ready
        if (dpm_in.supply_is_on) begin
          state_next.fsm = vcsfsm_pkg::initiator_send_ready_state;
          state_next.tx.msg = vcsfsm_pkg::msg_ps_rdy;
        end
      end
      vcsfsm_pkg::initiator_send_ready_state: begin
        // RQ2 back to ready
        if (rx.tx_done) begin
          state_next.fsm = vcsfsm_pkg::ready_state;
        end
      end
      vcsfsm_pkg::hard_reset_state: begin
        if (dpm_in.hard_reset_done) begin
          state_next.fsm = vcsfsm_pkg::ready_state;
        end
      end
      default: begin
        state_next.fsm = vcsfsm_pkg::ready_state;
      end
    endcase

    // RQ5 RQ8 RQ14 transmit while in sending states
    state_next.tx.req = (state_next.fsm == vcsfsm_pkg::responder_accept_state) ||
                        (state_next.fsm == vcsfsm_pkg::responder_refuse_state) ||
                        (state_next.fsm == vcsfsm_pkg::responder_send_ready_state) ||
                        (state_next.fsm == vcsfsm_pkg::initiator_send_ready_state);
    // RQ1 RQ13 supply on request
    state_next.dpm.supply_on_req =
      (state_next.fsm == vcsfsm_pkg::responder_supply_on_state) ||
      (state_next.fsm == vcsfsm_pkg::initiator_supply_on_state);
    // RQ12 supply off request
    state_next.dpm.supply_off_req =
      (state_next.fsm == vcsfsm_pkg::responder_supply_off_state);
    // RQ16 ask for evaluation
    state_next.dpm.eval_req = (state_next.fsm == vcsfsm_pkg::eval_state);
    // RQ11 hard reset by role
    if (state_next.fsm != vcsfsm_pkg::hard_reset_state) begin
      state_next.hard_reset_src = 1'b0;
      state_next.hard_reset_snk = 1'b0;
    end else if (state_reg.fsm != vcsfsm_pkg::hard_reset_state) begin
      state_next.hard_reset_src = role_is_source;
      state_next.hard_reset_snk = !role_is_source;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg.fsm <= vcsfsm_pkg::ready_state;
      state_reg.timer <= '0;
      state_reg.tx.req <= 1'b0;
      state_reg.tx.msg <= vcsfsm_pkg::msg_ps_rdy;
      state_reg.dpm.supply_on_req <= vcsfsm_pkg::RST_SUPPLY_ON_REQ;
      state_reg.dpm.supply_off_req <= vcsfsm_pkg::RST_SUPPLY_OFF_REQ;
      state_reg.dpm.eval_req <= 1'b0;
      state_reg.hard_reset_src <= 1'b0;
      state_reg.hard_reset_snk <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign tx = state_reg.tx;
  assign dpm_out = state_reg.dpm;
  // RQ2 RQ9 RQ12 ready by role
  assign source_ready = (state_reg.fsm == vcsfsm_pkg::ready_state) && role_is_source;
  assign sink_ready = (state_reg.fsm == vcsfsm_pkg::ready_state) && !role_is_source;
  assign hard_reset_src = state_reg.hard_reset_src;
  assign hard_reset_snk = state_reg.hard_reset_snk;

endmodule : vcsfsm_top

// ---- tb/vcsfsm_assertions.sv ----
/* Port checker of the cable-supply swap machine.
   Assumes binding into vcsfsm_top with its SUPPLY_ON_CYCLES. */
`timescale 1ns/100ps
module vcsfsm_assertions #(
  parameter int unsigned SUPPLY_ON_CYCLES = 20
) (
  input wire logic ref_clk, // Clock
  input wire logic sys_rst, // Sync reset
  input wire logic role_is_source, // Power role
  input wire vcsfsm_pkg::vcsfsm_rx_type rx, // Protocol events
  input wire vcsfsm_pkg::vcsfsm_dpm_in_type dpm_in, // Manager answers
  input wire vcsfsm_pkg::vcsfsm_tx_type tx, // Send request
  input wire vcsfsm_pkg::vcsfsm_dpm_out_type dpm_out, // Manager requests
  input wire logic source_ready, // Source ready
  input wire logic sink_ready, // Sink ready
  input wire logic hard_reset_src, // Source hard reset
  input wire logic hard_reset_snk // Sink hard reset
);
  logic rdy, idle, sent, acc;
  logic [31:0] idle_cnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Decoded views of the outputs
  assign rdy = source_ready | sink_ready;
  assign sent = tx.req & rx.tx_done;
  assign acc = tx.msg == vcsfsm_pkg::msg_accept;
  assign idle = !(rdy | tx.req | dpm_out.eval_req | dpm_out.supply_on_req
    | dpm_out.supply_off_req | hard_reset_src | hard_reset_snk);
  // Cycles spent silently waiting for the partner supply
  always_ff @(posedge ref_clk) begin
    idle_cnt <= (sys_rst || !idle) ? 32'h0 : idle_cnt + 32'h1;
  end
  a_ready_eval: assert property (rdy && rx.swap_rcvd |=> dpm_out.eval_req)
    else $error("no evaluation");
  a_eval_accept: assert property (dpm_out.eval_req && dpm_in.swap_ok |=> tx.req && acc)
    else $error("no accept");
  a_eval_refuse: assert property (dpm_out.eval_req && !dpm_in.swap_ok && dpm_in.swap_reject
    |=> tx.req && tx.msg == vcsfsm_pkg::msg_reject) else $error("no reject");
  a_on_send: assert property (dpm_out.supply_on_req && dpm_in.supply_is_on
    |=> tx.req && tx.msg == vcsfsm_pkg::msg_ps_rdy) else $error("no ready message");
  a_sent_ready: assert property (sent && !acc |=> rdy) else $error("no return");
  a_acc_off: assert property (sent && acc && !dpm_in.supply_is_on
    |=> dpm_out.supply_on_req && !tx.req) else $error("no supply on");
  a_acc_on: assert property (sent && acc && dpm_in.supply_is_on |=> idle)
    else $error("no partner wait");
  a_wait_psrdy: assert property (idle && rx.ps_rdy_rcvd |=> dpm_out.supply_off_req)
    else $error("no supply off");
  a_off_ready: assert property (dpm_out.supply_off_req && !dpm_in.supply_is_on |=> rdy)
    else $error("no return after off");
  a_timeout_hr: assert property ($rose(hard_reset_src || hard_reset_snk)
    |-> idle_cnt == SUPPLY_ON_CYCLES && hard_reset_src == role_is_source)
    else $error("hard reset timing");
endmodule : vcsfsm_assertions

// ---- tb/vcsfsm_partner.sv ----
/* Partner model: protocol layer sending and the manager's supply switch.
   Answers DLY+1 cycles after a request appears; requests stand until answered. */
`timescale 1ns/100ps
module vcsfsm_partner #(
  parameter int DLY = 3
) (
  input wire logic ref_clk, // Clock
  input wire logic sys_rst, // Sync reset
  input wire vcsfsm_pkg::vcsfsm_tx_type tx, // Send request
  input wire vcsfsm_pkg::vcsfsm_dpm_out_type dpm_out, // Supply requests
  output logic tx_done = 1'b0, // Message sent pulse
  output logic supply_is_on = 1'b0 // Supply level
);
  int tcnt = 0;
  int scnt = 0;
  always @(posedge ref_clk) begin
    tcnt <= (sys_rst || !tx.req || tx_done) ? 0 : tcnt + 1;
    tx_done <= !sys_rst && tx.req && !tx_done && tcnt == DLY;
  end
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      scnt <= 0;
      supply_is_on <= 1'b0;
    end else if (dpm_out.supply_on_req != dpm_out.supply_off_req
      && supply_is_on == dpm_out.supply_off_req) begin
      scnt <= (scnt == DLY) ? 0 : scnt + 1;
      supply_is_on <= (scnt == DLY) ? dpm_out.supply_on_req : supply_is_on;
    end else begin
      scnt <= 0;
    end
  end
endmodule : vcsfsm_partner

// ---- tb/test_vconn_swap_policy_fsm.sv ----
/* Bench of the cable-supply swap machine.
   Drives protocol and manager events; the partner model answers sends and supply. */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; $display("Error %s exp %0h got %0h", nm, e, g); end end
`define WT(c) begin n = 0; while (!(c) && n < 200) begin @(posedge ref_clk); #1; n++; end if (n >= 200) begin error_cnt++; finish_test(); end end
`define PL(s) begin s = 1'b1; @(posedge ref_clk); #1; s = 1'b0; end
module test_vconn_swap_policy_fsm;
  logic ref_clk = 1'b0, sys_rst = 1'b1, role = 1'b1, sw = 1'b0, pr = 1'b0, ok = 1'b0;
  logic rj = 1'b0, wt = 1'b0, go = 1'b0, hrd = 1'b0, txd, son, src_rdy, snk_rdy, hrs, hrk;
  int error_cnt = 0, n_checks = 0, n;
  vcsfsm_pkg::vcsfsm_tx_type tx;
  vcsfsm_pkg::vcsfsm_dpm_out_type dpo;
  vcsfsm_pkg::vcsfsm_rx_type rx;
  vcsfsm_pkg::vcsfsm_dpm_in_type dpi;
  assign rx = {sw, pr, txd};
  assign dpi = {son, ok, rj, wt, go, hrd};
  always #4 ref_clk = ~ref_clk;
  vcsfsm_top #(.SUPPLY_ON_CYCLES(20)) i_vcsfsm_top (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .role_is_source(role), .rx(rx), .dpm_in(dpi), .tx(tx), .dpm_out(dpo),
    .source_ready(src_rdy), .sink_ready(snk_rdy), .hard_reset_src(hrs), .hard_reset_snk(hrk));
  vcsfsm_partner #(.DLY(3)) i_vcsfsm_partner (.ref_clk(ref_clk), .sys_rst(sys_rst), .tx(tx),
    .dpm_out(dpo), .tx_done(txd), .supply_is_on(son));
  task automatic finish_test();
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  // Swap request, then the manager verdict
  task automatic swap(input logic r, input logic a, input logic w);
    role = r;
    `PL(sw)
    `CHK("eval_req", 1'b1, dpo.eval_req)
    if (a) `PL(ok) else if (w) `PL(wt) else `PL(rj)
  endtask : swap
  task automatic t_init();
    `PL(go)
    `CHK("supply_on_req", 1'b1, dpo.supply_on_req)
    `WT(tx.req)
    `CHK("ps_rdy", vcsfsm_pkg::msg_ps_rdy, tx.msg)
    `WT(!tx.req)
    `CHK("ready", 2'h2, {src_rdy, snk_rdy})
  endtask : t_init
  task automatic t_accept(input logic r);
    swap(r, 1'b1, 1'b0);
    `CHK("accept", {1'b1, vcsfsm_pkg::msg_accept}, tx)
    `WT(!tx.req)
    if (son) begin
      `CHK("wait quiet", 4'h0, {dpo, src_rdy})
      `PL(pr)
      `CHK("supply_off_req", 1'b1, dpo.supply_off_req)
      `WT(src_rdy | snk_rdy)
      `CHK("supply off", 1'b0, son)
    end else begin
      `CHK("supply_on_req", 1'b1, dpo.supply_on_req)
      `WT(tx.req)
      `CHK("ps_rdy", {son, vcsfsm_pkg::msg_ps_rdy}, {1'b1, tx.msg})
      `WT(!tx.req)
    end
    `CHK("ready", {r, !r}, {src_rdy, snk_rdy})
  endtask : t_accept
  task automatic t_refuse(input logic w);
    swap(1'b0, 1'b0, w);
    `CHK("refuse", w ? vcsfsm_pkg::msg_wait : vcsfsm_pkg::msg_reject, tx.msg)
    `WT(!tx.req)
    `CHK("ready", 2'h1, {src_rdy, snk_rdy})
  endtask : t_refuse
  task automatic t_timeout();
    swap(1'b0, 1'b1, 1'b0);
    `WT(!tx.req)
    `WT(hrk)
    `CHK("timeout", 20, n)
    `CHK("hard reset role", 2'h1, {hrs, hrk})
    `PL(hrd)
    `CHK("ready", 2'h1, {src_rdy, snk_rdy})
  endtask : t_timeout
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    t_init();
    t_accept(1'b1);
    t_accept(1'b0);
    t_refuse(1'b0);
    t_refuse(1'b1);
    t_timeout();
    finish_test();
  end
endmodule : test_vconn_swap_policy_fsm
bind vcsfsm_top vcsfsm_assertions #(.SUPPLY_ON_CYCLES(SUPPLY_ON_CYCLES)) i_vcsfsm_assertions (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .role_is_source(role_is_source), .rx(rx),
  .dpm_in(dpm_in), .tx(tx), .dpm_out(dpm_out), .source_ready(source_ready),
  .sink_ready(sink_ready), .hard_reset_src(hard_reset_src), .hard_reset_snk(hard_reset_snk));
